//--- design/ais_params.svh
/*
 * constants of the analog input scaler: register offsets, field positions,
 * reset values and arithmetic figures.
 * assumes inclusion by bare name from the package and the top module.
 */
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH

// register byte offsets
`define AIS_OFS_CTRL    8'h00
`define AIS_OFS_GAIN    8'h04
`define AIS_OFS_OFFSET  8'h08
`define AIS_OFS_STATUS  8'h0C
`define AIS_OFS_STD     8'h10
`define AIS_OFS_VALUE   8'h14
`define AIS_OFS_AOUT    8'h18

// control field positions
`define AIS_CTRL_KIND_LSB 0
`define AIS_CTRL_MODE_LSB 4

// reset values
`define AIS_RST_GAIN    16'sh0064
`define AIS_RST_OFFSET  16'sh0000

// arithmetic figures
`define AIS_STD_MAX     1000
`define AIS_STD_LZ      200
`define AIS_STD_LZ_SPAN 800
`define AIS_GAIN_MIN    (-1000)
`define AIS_GAIN_MAX    1000
`define AIS_OFF_MIN     (-10000)
`define AIS_OFF_MAX     10000
`define AIS_GAIN_DIV    100
`define AIS_MV_PER_LSB  10

`endif

//--- design/ais_pkg.sv
/*
 * types of the analog input scaler: sensor kinds, arithmetic modes and the
 * packed carriers of the register bus and the result.
 * assumes ais_params.svh is on the include path.
 */
`default_nettype none

package ais_pkg;
  `include "ais_params.svh"

  typedef enum logic [2:0] {
    AIS_VOLT, AIS_CURR, AIS_LIVE, AIS_RTD, AIS_NONE
  } ais_kind_t;

  typedef enum logic [1:0] {
    AIS_NORMAL, AIS_LEGACY, AIS_RESTRICT
  } ais_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ais_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ais_wb_rsp_t;

  typedef struct packed {
    logic               valid;
    logic [10:0]        std;
    logic signed [31:0] value;
    logic [10:0]        aout;
    logic [13:0]        volt_mv;
  } ais_res_t;
endpackage

`default_nettype wire

//--- design/ais_top.sv
/*
 * analog input scaler: turns a converter reading into a standardized value,
 * applies integer gain and offset and limits the analog output.
 * assumes a classic wishbone master and a converter giving one reading per
 * valid pulse, synchronous to I_CLOCK.
 */
// How it works
// - voltage or full current input maps to standardized 0..1000.
// - live-zero current loop maps to standardized 200..1000.
// - sensor kind picks voltage, current, live-zero, thermometer or none.
// - normal mode: standardized times gain, then plus signed offset.
// - gain accepts -10.00 to +10.00 in hundredths.
// - offset accepts signed integers -10000 to +10000.
// - all scaling uses whole-number integer arithmetic.
// - real analog output handles only 0..1000.
// - analog output becomes 0..10 V output voltage.
// - legacy mode: offset added first, then multiplied by percent gain.
// - legacy gain is a percentage and negative values are refused.
// - restricted mode refuses any negative gain.
`timescale 1ns/1ns
`default_nettype none
`include "ais_params.svh"

module ais_top
  import ais_pkg::*;
#(
  parameter int RAW_W  = 12,   // converter code width
  parameter int RAW_FS = 4095  // converter code at full scale
) (
  input  wire logic             I_CLOCK,     // system clock
  input  wire logic             I_RSTN,      // async reset, active low
  input  wire ais_wb_req_t      I_WB,        // wishbone request
  output ais_wb_rsp_t           O_WB,        // wishbone answer
  input  wire logic [RAW_W-1:0] I_RAW,       // converter reading
  input  wire logic             I_RAW_VALID, // reading strobe
  output ais_res_t              O_RES        // scaled result
);

  // reset release through two flip-flops
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // configuration and status state
  logic [2:0]         kind_q;
  logic [1:0]         mode_q;
  logic signed [15:0] gain_q;
  logic signed [15:0] off_q;
  logic [2:0]         err_q;
  logic               ack_q;
  logic [31:0]        rdat_q;
  ais_res_t           res_q;

  // bus decode
  wire        req_w  = I_WB.cyc & I_WB.stb;
  wire        wr_w   = req_w & I_WB.we & ack_q;  // write lands on the ack edge
  wire        hit_c  = I_WB.adr == `AIS_OFS_CTRL;
  wire        hit_g  = I_WB.adr == `AIS_OFS_GAIN;
  wire        hit_o  = I_WB.adr == `AIS_OFS_OFFSET;
  wire        hit_s  = I_WB.adr == `AIS_OFS_STATUS;
  wire [31:0] mask_w = {{8{I_WB.sel[3]}}, {8{I_WB.sel[2]}},
                        {8{I_WB.sel[1]}}, {8{I_WB.sel[0]}}};

  // readback words
  wire [31:0] ctrl_r = {26'd0, mode_q, 1'b0, kind_q};
  wire [31:0] gain_r = {{16{gain_q[15]}}, gain_q};
  wire [31:0] off_r  = {{16{off_q[15]}}, off_q};

  // candidate words after byte-lane merge
  wire [31:0]        ctrl_m = (ctrl_r & ~mask_w) | (I_WB.dat & mask_w);
  wire signed [31:0] gain_m = signed'((gain_r & ~mask_w) | (I_WB.dat & mask_w));
  wire signed [31:0] off_m  = signed'((off_r & ~mask_w) | (I_WB.dat & mask_w));
  wire [1:0]         mode_m = ctrl_m[`AIS_CTRL_MODE_LSB +: 2];

  // acceptance checks
  wire g_inrng = gain_m >= `AIS_GAIN_MIN && gain_m <= `AIS_GAIN_MAX;
  wire g_okdir = mode_q == AIS_NORMAL || gain_m >= 0;
  wire g_ok    = g_inrng & g_okdir;
  wire o_ok    = off_m >= `AIS_OFF_MIN && off_m <= `AIS_OFF_MAX;
  wire m_ok    = mode_m <= 2'(AIS_RESTRICT) &&
                 (mode_m == AIS_NORMAL || gain_q >= 0);

  // refusal events for the sticky status bits
  wire [2:0] rej_w = {wr_w & hit_c & ~m_ok, wr_w & hit_o & ~o_ok,
                      wr_w & hit_g & ~g_ok};

  // read mux, unmapped offsets read zero
  wire [31:0] rd_w =
    hit_c ? ctrl_r :
    hit_g ? gain_r :
    hit_o ? off_r :
    hit_s ? {29'd0, err_q} :
    I_WB.adr == `AIS_OFS_STD   ? {21'd0, res_q.std} :
    I_WB.adr == `AIS_OFS_VALUE ? res_q.value :
    I_WB.adr == `AIS_OFS_AOUT  ? {21'd0, res_q.aout} : 32'h0000_0000;

  // bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req_w & ~ack_q;
      rdat_q <= (req_w & ~ack_q) ? rd_w : rdat_q;
    end
  end
  assign O_WB = '{ack: ack_q, dat: rdat_q};

  // configuration writes; a refused gain, offset or mode keeps the old value, the kind field is always taken
  always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      kind_q <= 3'(AIS_VOLT);
      mode_q <= 2'(AIS_NORMAL);
      gain_q <= `AIS_RST_GAIN;
      off_q  <= `AIS_RST_OFFSET;
    end else begin
      if (wr_w & hit_c) begin
        kind_q <= ctrl_m[`AIS_CTRL_KIND_LSB +: 3];
        mode_q <= m_ok ? mode_m : mode_q;
      end
      if (wr_w & hit_g & g_ok) gain_q <= gain_m[15:0];
      if (wr_w & hit_o & o_ok) off_q <= off_m[15:0];
    end
  end

  // sticky refusal flags, write one to clear, a new refusal wins
  always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) err_q <= 3'd0;
    else err_q <= (err_q & ~((wr_w & hit_s) ? I_WB.dat[2:0] : 3'd0)) | rej_w;
  end

  // standardized value from the converter code
  wire [RAW_W-1:0] raw_c  = I_RAW > RAW_W'(RAW_FS) ? RAW_W'(RAW_FS) : I_RAW;
  wire [31:0]      raw_x  = 32'(raw_c);
  wire [31:0]      full_w = raw_x * 32'(`AIS_STD_MAX) / 32'(RAW_FS);
  wire [31:0]      live_w = 32'(`AIS_STD_LZ) +
                            raw_x * 32'(`AIS_STD_LZ_SPAN) / 32'(RAW_FS);
  wire [31:0]      rtd_w  = raw_x > 32'(`AIS_STD_MAX) ? 32'(`AIS_STD_MAX) : raw_x;
  wire [10:0]      std_d  =
    (kind_q == AIS_VOLT || kind_q == AIS_CURR) ? full_w[10:0] :
    kind_q == AIS_LIVE ? live_w[10:0] :
    kind_q == AIS_RTD  ? rtd_w[10:0] : 11'd0;

  // integer gain and offset arithmetic
  wire signed [31:0] std_s  = signed'({21'd0, std_d});
  wire signed [31:0] gain_s = 32'(gain_q);
  wire signed [31:0] off_s  = 32'(off_q);
  wire signed [31:0] norm_w = std_s * gain_s / `AIS_GAIN_DIV + off_s;
  wire signed [31:0] leg_w  = (std_s + off_s) * gain_s / `AIS_GAIN_DIV;
  wire signed [31:0] val_d  = mode_q == AIS_LEGACY ? leg_w : norm_w;

  // saturation for the real output and the voltage it stands for
  wire [10:0] aout_d = val_d < 0 ? 11'd0 :
                       val_d > `AIS_STD_MAX ? 11'(`AIS_STD_MAX) :
                       val_d[10:0];
  wire [13:0] mv_d   = 14'(aout_d) * 14'(`AIS_MV_PER_LSB);

  // result register, updated once per reading
  always_ff @(posedge I_CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      res_q <= '0;
    end else begin
      res_q.valid <= I_RAW_VALID;
      if (I_RAW_VALID) begin
        res_q.std     <= std_d;
        res_q.value   <= val_d;
        res_q.aout    <= aout_d;
        res_q.volt_mv <= mv_d;
      end
    end
  end
  assign O_RES = res_q;

  // checks on the design's own behaviour
  sequence s_req;
    req_w && !ack_q;
  endsequence

  sequence s_neg_gain_wr;
    wr_w && hit_g && mode_q != AIS_NORMAL && gain_m < 0;
  endsequence

  property p_ack_once;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      s_req |=> ack_q ##1 !ack_q;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle");

  property p_std_full;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      res_q.valid && ($past(kind_q) == AIS_VOLT || $past(kind_q) == AIS_CURR)
      |-> res_q.std <= `AIS_STD_MAX;
  endproperty
  a_std_full: assert property (p_std_full) else $error("full range value above 1000");

  property p_std_live;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      res_q.valid && $past(kind_q) == AIS_LIVE
      |-> res_q.std >= `AIS_STD_LZ && res_q.std <= `AIS_STD_MAX;
  endproperty
  a_std_live: assert property (p_std_live) else $error("live zero value out of range");

  property p_std_none;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      I_RAW_VALID && kind_q >= AIS_NONE |=> res_q.std == 11'd0;
  endproperty
  a_std_none: assert property (p_std_none) else $error("no sensor gave nonzero value");

  property p_normal;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      I_RAW_VALID && mode_q != AIS_LEGACY |=>
      res_q.value == $past(std_s) * $past(gain_s) / 100 + $past(off_s);
  endproperty
  a_normal: assert property (p_normal) else $error("normal scaling wrong");

  property p_legacy;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      I_RAW_VALID && mode_q == AIS_LEGACY |=>
      res_q.value == ($past(std_s) + $past(off_s)) * $past(gain_s) / 100;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy scaling wrong");

  property p_gain_range;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      gain_q >= -16'sd1000 && gain_q <= 16'sd1000;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range");

  property p_off_range;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      off_q >= -16'sd10000 && off_q <= 16'sd10000;
  endproperty
  a_off_range: assert property (p_off_range) else $error("offset out of range");

  property p_neg_refused;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      s_neg_gain_wr |=> $stable(gain_q) && err_q[0];
  endproperty
  a_neg_refused: assert property (p_neg_refused) else $error("negative gain taken");

  property p_nonneg_gain;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      mode_q != AIS_NORMAL |-> gain_q >= 0;
  endproperty
  a_nonneg_gain: assert property (p_nonneg_gain) else $error("negative gain in mode");

  property p_sat;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      res_q.valid |-> res_q.aout == (res_q.value < 0 ? 11'd0 :
        res_q.value > 1000 ? 11'd1000 : res_q.value[10:0]);
  endproperty
  a_sat: assert property (p_sat) else $error("output not saturated");

  property p_volt;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      res_q.aout <= 11'd1000 && res_q.volt_mv == 14'(res_q.aout) * 14'd10;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage mismatch");

  property p_off_refused;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      wr_w && hit_o && !o_ok |=> $stable(off_q) && err_q[1];
  endproperty
  a_off_refused: assert property (p_off_refused) else $error("bad offset taken");

  property p_mode_refused;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      wr_w && hit_c && !m_ok |=> $stable(mode_q) && err_q[2];
  endproperty
  a_mode_refused: assert property (p_mode_refused) else $error("bad mode taken");

  // a refusal always lands in the sticky flags, even beside a clear
  property p_set_wins;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      rej_w != 3'd0 |=> (err_q & $past(rej_w)) == $past(rej_w);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("refusal flag lost");

  property p_kind_taken;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      wr_w && hit_c |=> kind_q == $past(ctrl_m[`AIS_CTRL_KIND_LSB +: 3]);
  endproperty
  a_kind_taken: assert property (p_kind_taken) else $error("sensor kind not taken");

  property p_res_valid;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      I_RAW_VALID |=> res_q.valid;
  endproperty
  a_res_valid: assert property (p_res_valid) else $error("reading not answered");

  // a zero code on the live-zero loop sits at the raised floor
  property p_live_zero;
    @(posedge I_CLOCK) disable iff (!rst_n_q)
      I_RAW_VALID && kind_q == AIS_LIVE && I_RAW == '0 |=> res_q.std == 11'(`AIS_STD_LZ);
  endproperty
  a_live_zero: assert property (p_live_zero) else $error("live zero floor wrong");

endmodule // ais_top

`default_nettype wire

//--- verif/ais_top_tb_top.sv
/*
 * self-checking bench of the analog input scaler: register access over
 * classic wishbone, sensor kinds, gain and offset arithmetic, refusals.
 * assumes the design's one-cycle ack and one-cycle result latency.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ais_params.svh"

module ais_top_tb_top;
  import ais_pkg::*;

  logic        clk;
  logic        rstn;
  ais_wb_req_t wb_req;
  ais_wb_rsp_t wb_rsp;
  logic [11:0] raw;
  logic        raw_vld;
  ais_res_t    res;
  int          err_count;
  int          n_checks;

  ais_top u_dut (
    .I_CLOCK     (clk),
    .I_RSTN      (rstn),
    .I_WB        (wb_req),
    .O_WB        (wb_rsp),
    .I_RAW       (raw),
    .I_RAW_VALID (raw_vld),
    .O_RES       (res)
  );

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one compare, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("CHECK FAILED t=%0t ack=%h exp=%h", $time, wb_rsp.ack, 1'b1);
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb(1'b1, adr, dat, rd);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  // one converter reading, result checked the cycle after
  task automatic smp(input logic [11:0] code, input logic [31:0] s, input logic [31:0] v,
                     input logic [31:0] a);
    @(posedge clk);
    raw     <= code;
    raw_vld <= 1'b1;
    @(posedge clk);
    raw_vld <= 1'b0;
    #1;
    chk({31'h0, res.valid}, 32'h0000_0001);
    chk({21'h0, res.std}, s);
    chk(res.value, v);
    chk({21'h0, res.aout}, a);
    chk({18'h0, res.volt_mv}, a * 32'h0000_000A);
  endtask

  // reset values and an unmapped place
  task automatic t_reset;
    rdc(`AIS_OFS_CTRL, 32'h0000_0000);
    rdc(`AIS_OFS_GAIN, 32'h0000_0064);
    rdc(`AIS_OFS_OFFSET, 32'h0000_0000);
    rdc(`AIS_OFS_STATUS, 32'h0000_0000);
    wr(8'h20, 32'h1234_5678);
    rdc(8'h20, 32'h0000_0000);
  endtask

  // every sensor kind at unit gain, zero offset
  task automatic t_kinds;
    smp(12'hFFF, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8);
    smp(12'h800, 32'h0000_01F4, 32'h0000_01F4, 32'h0000_01F4);
    wr(`AIS_OFS_CTRL, 32'h0000_0001);
    smp(12'hFFF, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8);
    wr(`AIS_OFS_CTRL, 32'h0000_0002);
    smp(12'h000, 32'h0000_00C8, 32'h0000_00C8, 32'h0000_00C8);
    smp(12'hFFF, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8);
    wr(`AIS_OFS_CTRL, 32'h0000_0003);
    smp(12'h1F4, 32'h0000_01F4, 32'h0000_01F4, 32'h0000_01F4);
    smp(12'h7D0, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8);
    wr(`AIS_OFS_CTRL, 32'h0000_0004);
    smp(12'hFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    wr(`AIS_OFS_CTRL, 32'h0000_0007);
    smp(12'hFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    wr(`AIS_OFS_CTRL, 32'h0000_0000);
  endtask

  // normal mode arithmetic at range ends and saturation
  task automatic t_normal;
    wr(`AIS_OFS_GAIN, 32'h0000_000F); // every gain written is nonzero
    wr(`AIS_OFS_OFFSET, 32'hFFFF_FFCE);
    smp(12'h800, 32'h0000_01F4, 32'h0000_0019, 32'h0000_0019);
    wr(`AIS_OFS_OFFSET, 32'hFFFF_D8F0);
    smp(12'h800, 32'h0000_01F4, 32'hFFFF_D93B, 32'h0000_0000);
    wr(`AIS_OFS_GAIN, 32'h0000_03E8);
    wr(`AIS_OFS_OFFSET, 32'h0000_2710);
    smp(12'hFFF, 32'h0000_03E8, 32'h0000_4E20, 32'h0000_03E8);
    wr(`AIS_OFS_GAIN, 32'hFFFF_FC18);
    wr(`AIS_OFS_OFFSET, 32'h0000_0000);
    smp(12'hFFF, 32'h0000_03E8, 32'hFFFF_D8F0, 32'h0000_0000);
    wr(`AIS_OFS_GAIN, 32'hFFFF_FFF1);
    smp(12'h7FC, 32'h0000_01F3, 32'hFFFF_FFB6, 32'h0000_0000);
  endtask

  // out-of-range writes keep the field and set a sticky flag
  task automatic t_refuse;
    wr(`AIS_OFS_GAIN, 32'h0000_0064);
    wr(`AIS_OFS_GAIN, 32'h0000_03E9);
    rdc(`AIS_OFS_GAIN, 32'h0000_0064);
    wr(`AIS_OFS_OFFSET, 32'hFFFF_D8EF);
    rdc(`AIS_OFS_OFFSET, 32'h0000_0000);
    wr(`AIS_OFS_CTRL, 32'h0000_0030);
    rdc(`AIS_OFS_CTRL, 32'h0000_0000);
    rdc(`AIS_OFS_STATUS, 32'h0000_0007);
    wr(`AIS_OFS_STATUS, 32'h0000_0007);
    rdc(`AIS_OFS_STATUS, 32'h0000_0000);
  endtask

  // legacy and restricted modes refuse a negative gain
  task automatic t_modes;
    wr(`AIS_OFS_GAIN, 32'h0000_000F);
    wr(`AIS_OFS_OFFSET, 32'hFFFF_FFCE);
    wr(`AIS_OFS_CTRL, 32'h0000_0010);
    smp(12'h800, 32'h0000_01F4, 32'h0000_0043, 32'h0000_0043);
    wr(`AIS_OFS_GAIN, 32'hFFFF_FFF1);
    rdc(`AIS_OFS_STATUS, 32'h0000_0001);
    smp(12'h800, 32'h0000_01F4, 32'h0000_0043, 32'h0000_0043);
    wr(`AIS_OFS_STATUS, 32'h0000_0007);
    wr(`AIS_OFS_CTRL, 32'h0000_0020);
    smp(12'h800, 32'h0000_01F4, 32'h0000_0019, 32'h0000_0019);
    rdc(`AIS_OFS_STD, 32'h0000_01F4);
    rdc(`AIS_OFS_VALUE, 32'h0000_0019);
    rdc(`AIS_OFS_AOUT, 32'h0000_0019);
    wr(`AIS_OFS_GAIN, 32'hFFFF_FFF1);
    rdc(`AIS_OFS_STATUS, 32'h0000_0001);
    wr(`AIS_OFS_CTRL, 32'h0000_0000);
    wr(`AIS_OFS_GAIN, 32'hFFFF_FFF1);
    wr(`AIS_OFS_CTRL, 32'h0000_0010);
    rdc(`AIS_OFS_CTRL, 32'h0000_0000);
  endtask

  // reset, then the scenarios in turn
  initial begin
    err_count = 0;
    n_checks  = 0;
    rstn      = 1'b0;
    wb_req    = '0;
    raw       = 12'h000;
    raw_vld   = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_kinds();
    t_normal();
    t_refuse();
    t_modes();
    test_done();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule // ais_top_tb_top

`default_nettype wire
